// >>> verilog/sadcs_regs.vh
// constants of the serial converter sequencer
`ifndef SADCS_REGS_VH
`define SADCS_REGS_VH
`define SADCS_CMD_PWRDN 4'h8
`define SADCS_CMD_FAST 4'h9
`define SADCS_CMD_SLOW 4'hA
`define SADCS_CMD_W 4
`define SADCS_RES_W 10
`define SADCS_SAMP_START 4'h4
`define SADCS_SAMP_END 4'hA
`define SADCS_FRAME_LEN 5'h10
`define SADCS_CONV_DELAY 2'h2
`define SADCS_CS_SETUP 4'h3
`define SADCS_FAST_CYC 8'hC8
`define SADCS_SLOW_CYC 10'h320
`endif

// >>> verilog/sadcs_sync.v
// two-flop synchroniser with edge pulses taken from the synchronised level
`default_nettype none
module sadcs_sync (
	input wire sys_clk_in,
	input wire srst_in,
	input wire async_in,
	input wire rst_val_in,
	output wire level_out,
	output wire rise_out,
	output wire fall_out
);
	reg meta_ff;
	reg sync_ff;
	reg prev_ff;
	// first flop feeds only the second
	// reset loads the pin's idle level so no false edge follows reset
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			meta_ff <= rst_val_in;
			sync_ff <= rst_val_in;
			prev_ff <= rst_val_in;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end
	assign level_out = sync_ff;
	assign rise_out = sync_ff & ~prev_ff;
	assign fall_out = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// >>> verilog/sadcs_top.v
// sequencer for a serial successive-approximation converter
// Behaviour
// (RQ1) strobe fall starts sampling preset channel
// (RQ2) strobe rise holds the sample
// (RQ3) strobe discards waiting result
// (RQ4) conversion starts two clocks after strobe rise
// (RQ5) flag set on strobe rise, cleared on select rise
// (RQ6) flag tested at select fall
// (RQ7) normal cycle samples six serial clocks
// (RQ8) extended sampling: select high, strobe low
// (RQ9) host reads result with normal cycle
// (RQ10) rate codes 9h fast, Ah slow persist
// (RQ11) power-down keeps conversion rate
// (RQ12) code 8h powers down, select fall wakes
// (RQ13) reset: done high, input register zero
// (RQ14) host discards first results
// (RQ15) dsp mode: host lowers select and frame
// (RQ16) select toggle restarts the cycle
// (RQ17) host programs rate once at start; here the bench writes rate codes 9h, then Ah, then 9h again
// (RQ18) inverted clock samples input opposite edge
// (RQ19) inverted: output and input same edge; here inverted input samples on the edge opposite the output edge
// (RQ20) port mode from frame level at select fall
// (RQ21) control inputs ignored during select setup
// (RQ22) four-bit input register, msb first
// (RQ23) processor mode: msb at select fall
// (RQ24) dsp mode: msb after frame fall
// (RQ25) strobe synchronised before use
`default_nettype none
`include "sadcs_regs.vh"
module sadcs_top #(
	parameter RES_W = `SADCS_RES_W
) (
	input wire sys_clk_in,
	input wire srst_in,
	input wire chip_select_n_in,
	input wire serial_clk_in,
	input wire serial_in,
	input wire frame_sync_in,
	input wire conversion_start_n_in,
	input wire input_edge_invert_in,
	input wire [RES_W-1:0] conv_result_in,
	output wire serial_out,
	output wire serial_oe_out,
	output wire conversion_done_out,
	output wire sampling_out,
	output wire power_down_out,
	output wire slow_rate_out,
	output wire microprocessor_port_out,
	output wire pending_readout_flag_out,
	output wire [3:0] channel_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_CONV = 2'h2;

	// select next rate-dependent conversion length
	function [9:0] conv_len;
		input slow;
		begin
			conv_len = slow ? `SADCS_SLOW_CYC : {2'h0, `SADCS_FAST_CYC};
		end
	endfunction

	// --------------------------------------------------
	// input synchronisers
	// --------------------------------------------------
	wire cs_n_s, cs_rise, cs_fall;
	wire sclk_s, sclk_rise, sclk_fall;
	wire fs_s, fs_rise, fs_fall;
	wire cst_s, cst_rise, cst_fall;
	wire din_s, din_r, din_f;
	wire inv_s, inv_r, inv_f;
	sadcs_sync u_cs (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(chip_select_n_in),
		.rst_val_in(1'b1), .level_out(cs_n_s), .rise_out(cs_rise), .fall_out(cs_fall));
	sadcs_sync u_clk (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(serial_clk_in),
		.rst_val_in(1'b0), .level_out(sclk_s), .rise_out(sclk_rise), .fall_out(sclk_fall));
	sadcs_sync u_fs (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(frame_sync_in),
		.rst_val_in(1'b1), .level_out(fs_s), .rise_out(fs_rise), .fall_out(fs_fall));
	// (RQ25) strobe synchronised here
	sadcs_sync u_cst (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(conversion_start_n_in),
		.rst_val_in(1'b1), .level_out(cst_s), .rise_out(cst_rise), .fall_out(cst_fall));
	sadcs_sync u_din (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(serial_in),
		.rst_val_in(1'b0), .level_out(din_s), .rise_out(din_r), .fall_out(din_f));
	sadcs_sync u_inv (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(input_edge_invert_in),
		.rst_val_in(1'b1), .level_out(inv_s), .rise_out(inv_r), .fall_out(inv_f));

	// --------------------------------------------------
	// state
	// --------------------------------------------------
	reg mp_mode_ff;
	reg flag_ff;
	reg [3:0] shift_ff;
	reg [3:0] channel_ff;
	reg [2:0] in_cnt_ff;
	reg [4:0] clk_cnt_ff;
	reg [3:0] setup_ff;
	reg active_ff;
	reg conv_cycle_ff;
	reg framed_ff;
	reg sampling_ff;
	reg ext_samp_ff;
	reg [1:0] state_ff;
	reg [1:0] dly_ff;
	reg [9:0] conv_cnt_ff;
	reg done_ff;
	reg pwrdn_ff;
	reg slow_ff;
	reg [15:0] out_sr_ff;
	reg [RES_W-1:0] result_ff;
	reg result_valid_ff;
	reg out_bit_ff;
	reg oe_ff;
	reg start_conv;
	wire cycle_end;
	wire setup_ok = (setup_ff == `SADCS_CS_SETUP);

	// (RQ18) (RQ19) input sampling edge per mode and inversion
	wire in_edge = mp_mode_ff ? (inv_s ? sclk_rise : sclk_fall) : (inv_s ? sclk_fall : sclk_rise);
	// (RQ23) (RQ24) output change edge per mode
	wire out_edge = mp_mode_ff ? sclk_fall : sclk_rise;
	wire io_go = active_ff & setup_ok & framed_ff;

	// --------------------------------------------------
	// select, port mode and setup guard
	// --------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			mp_mode_ff <= 1'b1;
			active_ff <= 1'b0;
			setup_ff <= 4'h0;
			framed_ff <= 1'b0;
			conv_cycle_ff <= 1'b0;
		end else if (cs_fall) begin
			// (RQ20) port mode from frame level
			mp_mode_ff <= fs_s;
			active_ff <= 1'b1;
			setup_ff <= 4'h0;
			framed_ff <= fs_s;
			// (RQ6) flag tested here
			conv_cycle_ff <= ~flag_ff;
		end else if (cs_rise) begin
			active_ff <= 1'b0;
			framed_ff <= 1'b0;
		end else begin
			// (RQ21) hold off control inputs
			if (active_ff && !setup_ok) begin
				setup_ff <= setup_ff + 4'h1;
			end
			if (active_ff && !mp_mode_ff && setup_ok && fs_fall) begin
				framed_ff <= 1'b1;
			end
		end
	end

	// --------------------------------------------------
	// serial clock counting, input shift and sampling window
	// --------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			// (RQ13) input register cleared
			shift_ff <= 4'h0;
			channel_ff <= 4'h0;
			in_cnt_ff <= 3'h0;
			clk_cnt_ff <= 5'h0;
			sampling_ff <= 1'b0;
		end else if (cs_fall || cs_rise || (active_ff && !mp_mode_ff && fs_s && sclk_fall)) begin
			// (RQ16) new cycle on select toggle or frame
			in_cnt_ff <= 3'h0;
			clk_cnt_ff <= 5'h0;
			sampling_ff <= 1'b0;
		end else if (io_go) begin
			// (RQ22) msb-first shift of four bits
			if (in_edge && in_cnt_ff < 3'h4) begin
				shift_ff <= {shift_ff[2:0], din_s};
				in_cnt_ff <= in_cnt_ff + 3'h1;
				if (in_cnt_ff == 3'h3) begin
					channel_ff <= {shift_ff[2:0], din_s};
				end
			end
			if (sclk_rise && clk_cnt_ff < `SADCS_FRAME_LEN) begin
				clk_cnt_ff <= clk_cnt_ff + 5'h1;
			end
			// (RQ7) six-clock sampling window
			if (conv_cycle_ff && sclk_rise && clk_cnt_ff == {1'b0, `SADCS_SAMP_START} - 5'h1) begin
				sampling_ff <= 1'b1;
			end
			if (sclk_fall && clk_cnt_ff == {1'b0, `SADCS_SAMP_END}) begin
				sampling_ff <= 1'b0;
			end
		end
	end
	assign cycle_end = sampling_ff & io_go & sclk_fall & (clk_cnt_ff == {1'b0, `SADCS_SAMP_END});

	// --------------------------------------------------
	// pending readout flag and extended sampling
	// --------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			flag_ff <= 1'b0;
			ext_samp_ff <= 1'b0;
		end else begin
			// (RQ1) (RQ8) strobe fall with select high
			if (cst_fall && cs_n_s) begin
				ext_samp_ff <= 1'b1;
			end else if (cst_rise) begin
				// (RQ2) sample held here
				ext_samp_ff <= 1'b0;
			end
			// (RQ5) set wins over clear
			if (cst_rise) begin
				flag_ff <= 1'b1;
			end else if (cs_rise) begin
				flag_ff <= 1'b0;
			end
		end
	end

	// --------------------------------------------------
	// rate and power-down commands
	// --------------------------------------------------
	wire cmd_done = io_go & in_edge & (in_cnt_ff == 3'h3);
	wire [3:0] cmd = {shift_ff[2:0], din_s};
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			pwrdn_ff <= 1'b0;
			slow_ff <= 1'b0;
		end else begin
			// (RQ10) (RQ11) rate held across power-down
			if (cmd_done && cmd == `SADCS_CMD_FAST) begin
				slow_ff <= 1'b0;
			end else if (cmd_done && cmd == `SADCS_CMD_SLOW) begin
				slow_ff <= 1'b1;
			end
			// (RQ12) power-down entry and wake
			if (cmd_done && cmd == `SADCS_CMD_PWRDN) begin
				pwrdn_ff <= 1'b1;
			end else if (cs_fall) begin
				pwrdn_ff <= 1'b0;
			end
		end
	end

	// --------------------------------------------------
	// conversion sequencer
	// --------------------------------------------------
	always @* begin
		start_conv = 1'b0;
		if (state_ff == ST_WAIT && dly_ff == `SADCS_CONV_DELAY - 2'h1) begin
			start_conv = 1'b1;
		end
	end
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_ff <= ST_IDLE;
			dly_ff <= 2'h0;
			conv_cnt_ff <= 10'h0;
			// (RQ13) done starts high
			done_ff <= 1'b1;
			result_ff <= {RES_W{1'b0}};
			result_valid_ff <= 1'b0;
		end else begin
			// (RQ3) strobe discards waiting result
			if (cst_fall) begin
				result_valid_ff <= 1'b0;
			end
			case (state_ff)
				ST_IDLE: begin
					if (cst_rise) begin
						// (RQ4) two-clock delay before conversion
						state_ff <= ST_WAIT;
						dly_ff <= 2'h0;
						done_ff <= 1'b0;
					end else if (cycle_end && !pwrdn_ff) begin
						state_ff <= ST_CONV;
						conv_cnt_ff <= conv_len(slow_ff);
						done_ff <= 1'b0;
					end
				end
				ST_WAIT: begin
					dly_ff <= dly_ff + 2'h1;
					if (start_conv) begin
						state_ff <= ST_CONV;
						conv_cnt_ff <= conv_len(slow_ff);
					end
				end
				ST_CONV: begin
					if (conv_cnt_ff == 10'h1) begin
						state_ff <= ST_IDLE;
						done_ff <= 1'b1;
						result_ff <= conv_result_in;
						result_valid_ff <= 1'b1;
					end else begin
						conv_cnt_ff <= conv_cnt_ff - 10'h1;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// serial output
	// --------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			out_sr_ff <= 16'h0000;
			out_bit_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (cs_rise) begin
			oe_ff <= 1'b0;
		end else if (cs_fall && fs_s) begin
			// (RQ23) msb at select fall
			out_sr_ff <= {result_ff, 6'h00};
			out_bit_ff <= result_ff[RES_W-1];
			oe_ff <= 1'b1;
		end else if (cs_fall) begin
			out_sr_ff <= {result_ff, 6'h00};
			oe_ff <= 1'b1;
		end else if (active_ff && !mp_mode_ff && setup_ok && fs_fall) begin
			// (RQ24) msb after frame fall
			out_bit_ff <= out_sr_ff[15];
		end else if (io_go && out_edge && clk_cnt_ff != 5'h0) begin
			out_sr_ff <= {out_sr_ff[14:0], 1'b0};
			out_bit_ff <= out_sr_ff[14];
		end
	end

	assign serial_out = out_bit_ff;
	assign serial_oe_out = oe_ff;
	assign conversion_done_out = done_ff;
	assign sampling_out = sampling_ff | ext_samp_ff;
	assign power_down_out = pwrdn_ff;
	assign slow_rate_out = slow_ff;
	assign microprocessor_port_out = mp_mode_ff;
	assign pending_readout_flag_out = flag_ff;
	assign channel_out = channel_ff;
	wire unused_ok = din_r | din_f | inv_r | inv_f | fs_rise | result_valid_ff | sclk_s | cst_s;
endmodule
`default_nettype wire

// >>> verification/sadcs_top_monitor.sv
// port checker of the converter sequencer
`default_nettype none
module sadcs_top_monitor (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic chip_select_n_in,
	input wire logic frame_sync_in,
	input wire logic conversion_start_n_in,
	input wire logic serial_oe_out,
	input wire logic conversion_done_out,
	input wire logic sampling_out,
	input wire logic power_down_out,
	input wire logic slow_rate_out,
	input wire logic microprocessor_port_out,
	input wire logic pending_readout_flag_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// ----
	// port relations
	// ----
	flag_set_a: assert property ($rose(conversion_start_n_in) |-> ##[2:5] pending_readout_flag_out)
		else $error("flag not set after strobe");
	flag_clr_a: assert property ((conversion_start_n_in[*6] ##0 $rose(chip_select_n_in)) ##1
		conversion_start_n_in[*5] |-> !pending_readout_flag_out) else $error("flag not cleared");
	conv_go_a: assert property ($rose(conversion_start_n_in) && chip_select_n_in |-> ##[2:6]
		!conversion_done_out) else $error("conversion did not start");
	ext_samp_a: assert property ((chip_select_n_in && !conversion_start_n_in)[*5] |-> sampling_out)
		else $error("no sampling while strobe low");
	oe_idle_a: assert property (chip_select_n_in[*6] |-> !serial_oe_out)
		else $error("output driven while deselected");
	rate_keep_a: assert property ($changed(power_down_out) |-> $stable(slow_rate_out))
		else $error("rate moved with power state");
	pd_wake_a: assert property (power_down_out && $fell(chip_select_n_in) |-> ##[1:5] !power_down_out)
		else $error("select fall did not wake");
	mp_mode_a: assert property (($fell(chip_select_n_in) && frame_sync_in) ##1
		(frame_sync_in && !chip_select_n_in)[*5] |-> microprocessor_port_out) else $error("mode not processor");
endmodule
bind sadcs_top sadcs_top_monitor i_sadcs_top_monitor (.sys_clk_in, .srst_in, .chip_select_n_in,
	.frame_sync_in, .conversion_start_n_in, .serial_oe_out, .conversion_done_out, .sampling_out,
	.power_down_out, .slow_rate_out, .microprocessor_port_out, .pending_readout_flag_out);
`default_nettype wire

// >>> verification/sadcs_host.sv
// host serial port model for the converter link
`default_nettype none
module sadcs_host (
	input wire logic sys_clk_in,
	input wire logic sdo_in,
	input wire logic sdo_oe_in,
	output var logic cs_n_out,
	output var logic sclk_out,
	output var logic sdata_out,
	output var logic fs_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_ff = 1'b0;
	// released data line shows the inverse of its last level
	wire logic line = sdo_oe_in ? sdo_in : ~last_ff;
	always @(posedge sys_clk_in) begin
		if (sdo_oe_in)
			last_ff <= sdo_in;
	end
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		fs_out = 1'b1;
	end
	// ----
	// transfers
	// ----
	task automatic step(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// one cycle: four command bits out, sixteen bits back
	task automatic xfer(input logic [3:0] cmd, input logic mp, input logic inv, output logic [15:0] rx);
		logic b;
		logic rise;
		rise = mp ~^ inv;
		fs_out <= mp;
		cs_n_out <= 1'b0;
		step(12);
		if (!mp) begin
			fs_out <= 1'b1;
			step(8);
			fs_out <= 1'b0;
			step(4);
		end
		for (int i = 0; i < 16; i++) begin
			b = (i < 4) ? cmd[3 - i] : 1'b0;
			step(2);
			sdata_out <= rise ? b : ~b;
			step(2);
			sclk_out <= 1'b1;
			step(2);
			sdata_out <= rise ? ~b : b;
			step(2);
			// both modes read the bit just before the clock falls
			rx[15 - i] = line;
			sclk_out <= 1'b0;
		end
		step(4);
		cs_n_out <= 1'b1;
		fs_out <= 1'b1;
		step(8);
	endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench of the converter sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] RES_A = 10'h2A5;
	localparam logic [9:0] RES_B = 10'h15A;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic cst_n = 1'b1;
	logic inv = 1'b1;
	logic [9:0] res = RES_A;
	logic [15:0] rx;
	wire logic cs_n, sclk, sdi, fs, sdo, oe, done, samp, pd, slow, mp, flag;
	wire logic [3:0] chan;
	int err_total = 0;
	int n_compared = 0;
	// row: command, processor mode, edge, slow, power-down, readout valid
	logic [8:0] rows [7] = '{9'h138, 9'h154, 9'h11E, 9'h074, 9'h139, 9'h0A9, 9'h0C1};
	always #25 sys_clk_in = ~sys_clk_in;
	sadcs_top i_sadcs_top (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .chip_select_n_in(cs_n),
		.serial_clk_in(sclk), .serial_in(sdi), .frame_sync_in(fs), .conversion_start_n_in(cst_n),
		.input_edge_invert_in(inv), .conv_result_in(res), .serial_out(sdo), .serial_oe_out(oe),
		.conversion_done_out(done), .sampling_out(samp), .power_down_out(pd), .slow_rate_out(slow),
		.microprocessor_port_out(mp), .pending_readout_flag_out(flag), .channel_out(chan));
	sadcs_host i_sadcs_host (.sys_clk_in(sys_clk_in), .sdo_in(sdo), .sdo_oe_in(oe), .cs_n_out(cs_n),
		.sclk_out(sclk), .sdata_out(sdi), .fs_out(fs));
	// ----
	// helpers
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_idle();
		int n = 0;
		while (done !== 1'b1 && n < 1200) begin
			@(negedge sys_clk_in);
			n++;
		end
		chk(16'(done), 16'h0001);
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		err_total++;
		close_out();
	end
	// ----
	// sequence
	// ----
	initial begin
		repeat (10) @(negedge sys_clk_in);
		srst_in = 1'b0;
		chk(16'({done, flag, oe, chan, slow, pd, mp}), 16'h0201);
		repeat (4) @(negedge sys_clk_in);
		// early readouts are ignored by the host
		for (int i = 0; i < 7; i++) begin
			inv = rows[i][3];
			i_sadcs_host.xfer(rows[i][8:5], rows[i][4], rows[i][3], rx);
			chk(16'(chan), 16'(rows[i][8:5]));
			chk(16'({slow, pd}), 16'(rows[i][2:1]));
			chk(16'(mp), 16'(rows[i][4]));
			if (rows[i][0])
				chk(rx, {res, 6'h00});
			wait_idle();
		end
		$display("test rows done");
		inv = 1'b1;
		res = RES_B;
		cst_n = 1'b0;
		repeat (20) @(negedge sys_clk_in);
		chk(16'(samp), 16'h0001);
		cst_n = 1'b1;
		repeat (6) @(negedge sys_clk_in);
		chk(16'({flag, done, samp}), 16'h0004);
		wait_idle();
		i_sadcs_host.xfer(4'h2, 1'b1, 1'b1, rx);
		chk(rx, {RES_B, 6'h00});
		chk(16'({flag, done}), 16'h0001);
		i_sadcs_host.xfer(4'h4, 1'b1, 1'b1, rx);
		chk(16'(done), 16'h0000);
		$display("test extended done");
		srst_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		srst_in = 1'b0;
		chk(16'({done, flag, oe, chan, slow, pd, mp}), 16'h0201);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
